// ==== verilog/ssgr_pkg.sv ====
// ============================================================
// Shared constants and types for the sampling readout block.
package ssgr_pkg;

  // ============================================================
  // Clock and sampling timing.
  localparam int CLK_NS = 100;
  localparam int FAST_PERIOD_NS = 1000000;
  localparam int FAST_SAMPLE_NS = 300000;
  localparam int SLOW_PERIOD_NS = 2000000;
  localparam int SLOW_SAMPLE_NS = 600000;
  localparam int FAST_PERIOD_CYC = (FAST_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int FAST_SAMPLE_CYC = (FAST_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOW_PERIOD_CYC = (SLOW_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOW_SAMPLE_CYC = (SLOW_SAMPLE_NS + CLK_NS - 1) / CLK_NS;

  // ============================================================
  // Input word codes.
  localparam int WORD_W = 16;
  localparam logic [15:0] W_SENTINEL = 16'hbbbb;
  localparam logic [15:0] W_CPU_ERR = 16'hbeee;
  localparam logic [15:0] W_CAL_ERR = 16'hb010;
  localparam logic [15:0] W_SET_ERR = 16'hb011;
  localparam logic [15:0] W_BREAK = 16'hb001;
  localparam logic [15:0] W_OVER = 16'hb000;
  localparam int BIT_BREAK = 15;
  localparam int BIT_OVER = 14;

  // ============================================================
  // Command answers and command codes.
  localparam logic [15:0] R_BAD_CMD = 16'he000;
  localparam logic [15:0] R_BAD_PARAM = 16'he001;
  localparam logic [15:0] R_TEACH_ERR = 16'he002;
  localparam logic [15:0] R_MODE_ERR = 16'he003;
  localparam logic [7:0] OP_TEACH = 8'hc1;
  localparam logic [7:0] OP_NORM_A = 8'hc5;
  localparam logic [7:0] OP_NORM_B = 8'hc8;
  localparam logic [7:0] OP_NORM_C = 8'hcc;
  localparam logic [7:0] PARAM_MAX = 8'h63;

  // ============================================================
  // Configuration and health types.
  localparam int MEAN_LW = 2;
  typedef enum logic [1:0] {
    HOLD_NORMAL,
    HOLD_SAMPLE,
    HOLD_GATE
  } ssgr_hold_t;

  typedef struct packed {
    ssgr_hold_t hold;
    logic slow;
    logic compare;
    logic [MEAN_LW-1:0] mean_log2;
  } ssgr_cfg_t;

  typedef struct packed {
    logic cpu_fault;
    logic cal_fault;
    logic set_fault;
    logic sensor_break;
    logic overflow;
  } ssgr_health_t;

endpackage

// ==== verilog/ssgr_pacer.sv ====
`timescale 1ns/10ps
// ============================================================
// Sampling pacer: one sample window at the start of each period.
module ssgr_pacer
  import ssgr_pkg::*;
#(
  parameter int FAST_PER = FAST_PERIOD_CYC,
  parameter int FAST_SMP = FAST_SAMPLE_CYC,
  parameter int SLOW_PER = SLOW_PERIOD_CYC,
  parameter int SLOW_SMP = SLOW_SAMPLE_CYC
) (
  input logic i_mclk,
  input logic i_srst,
  input logic i_run,
  input logic i_slow,
  output logic o_take,
  output logic o_sampling
);
  localparam int CNT_W = $clog2(SLOW_PER + 1);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] per_last;
  logic [CNT_W-1:0] smp_last;
  logic next_take;
  logic next_sampling;
  logic [CNT_W:0] gap;
  logic armed;
  logic slow_q;

  // Period counter restarts whenever the run request drops.
  always_comb begin
    per_last = i_slow ? CNT_W'(SLOW_PER - 1) : CNT_W'(FAST_PER - 1);
    smp_last = i_slow ? CNT_W'(SLOW_SMP - 1) : CNT_W'(FAST_SMP - 1);
    next_cnt = '0;
    if (i_run && cnt < per_last) begin
      next_cnt = cnt + 1'b1;
    end
    next_take = i_run && cnt == smp_last;
    next_sampling = i_run && cnt <= smp_last;
  end

  // Registers of the pacer.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt <= '0;
      o_take <= 1'b0;
      o_sampling <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_take <= next_take;
      o_sampling <= next_sampling;
    end
  end

  // Gap counter between two sample strobes, read only by a check.
  // A change of speed disarms it, as that period mixes both speeds.
  always_ff @(posedge i_mclk) begin
    slow_q <= i_slow;
    if (i_srst || !i_run || i_slow != slow_q) begin
      gap <= '0;
      armed <= 1'b0;
    end else if (o_take) begin
      gap <= '0;
      armed <= 1'b1;
    end else begin
      gap <= gap + 1'b1;
    end
  end

  take_period_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    o_take && armed && $stable(i_slow) && $past(i_run)
      |-> gap == {1'b0, per_last})
    else $error("Sample strobes not one period apart.");

endmodule

// ==== verilog/ssgr_mean.sv ====
`timescale 1ns/10ps
// ============================================================
// Mean value unit: sums a power-of-two count of samples.
module ssgr_mean
  import ssgr_pkg::*;
#(
  parameter int DW = WORD_W,
  parameter int LW = MEAN_LW
) (
  input logic i_mclk,
  input logic i_srst,
  input logic i_clear,
  input logic i_add,
  input logic [DW-1:0] i_data,
  input logic [LW-1:0] i_log2,
  output logic o_done,
  output logic [DW-1:0] o_mean
);
  localparam int ACC_W = DW + (2 ** LW) - 1;
  localparam int CW = 2 ** LW;

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [ACC_W-1:0] sum;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_done;
  logic [DW-1:0] next_mean;

  // Accumulate; the last sample of a block yields the mean.
  always_comb begin
    sum = acc + ACC_W'(i_data);
    next_acc = acc;
    next_cnt = cnt;
    next_done = 1'b0;
    next_mean = o_mean;
    if (i_clear) begin
      next_acc = '0;
      next_cnt = '0;
    end else if (i_add) begin
      if (cnt + 1'b1 == (CW'(1) << i_log2)) begin
        next_mean = DW'(sum >> i_log2);
        next_done = 1'b1;
        next_acc = '0;
        next_cnt = '0;
      end else begin
        next_acc = sum;
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Registers of the mean unit.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      acc <= '0;
      cnt <= '0;
      o_done <= 1'b0;
      o_mean <= '0;
    end else begin
      acc <= next_acc;
      cnt <= next_cnt;
      o_done <= next_done;
      o_mean <= next_mean;
    end
  end

endmodule

// ==== verilog/ssgr_top.sv ====
`timescale 1ns/10ps
// ============================================================
module ssgr_top
  import ssgr_pkg::*;
#(
  parameter int FAST_PER = FAST_PERIOD_CYC,
  parameter int FAST_SMP = FAST_SAMPLE_CYC,
  parameter int SLOW_PER = SLOW_PERIOD_CYC,
  parameter int SLOW_SMP = SLOW_SAMPLE_CYC
) (
  input logic i_mclk,
  input logic i_srst,
  input logic i_trig,
  input logic i_rst_in,
  input ssgr_cfg_t i_cfg,
  input logic [WORD_W-1:0] i_sample,
  input ssgr_health_t i_health,
  input logic i_cmd_valid,
  input logic [WORD_W-1:0] i_cmd,
  output logic [WORD_W-1:0] o_word,
  output logic o_word_new,
  output logic o_err_lamp,
  output logic o_break_lamp,
  output logic o_sampling,
  output logic [WORD_W-1:0] o_resp,
  output logic o_resp_valid
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_WRITE
  } ssgr_state_t;

  ssgr_state_t state;
  ssgr_state_t next_state;
  logic trig_q;
  logic next_trig;
  logic is_normal;
  logic is_shold;
  logic is_gate;
  logic trig_rise;
  logic gate_open;
  logic run;
  logic take;
  logic mean_clear;
  logic mean_done;
  logic [WORD_W-1:0] mean_val;
  logic any_fault;
  logic [WORD_W-1:0] next_word;
  logic [WORD_W-1:0] base;
  logic next_new;
  logic next_err;
  logic next_brk;
  logic [7:0] op;
  logic [7:0] param;
  logic [WORD_W-1:0] next_resp;
  logic next_resp_valid;

  // ============================================================
  // Command decode helpers.

  // Tells whether an opcode is one the unit knows.
  function automatic logic op_known(input logic [7:0] code);
    op_known = code == OP_TEACH || op_norm_only(code);
  endfunction

  // Tells whether an opcode is allowed only in normal hold.
  function automatic logic op_norm_only(input logic [7:0] code);
    op_norm_only = code == OP_NORM_A || code == OP_NORM_B ||
                   code == OP_NORM_C;
  endfunction

  // ============================================================
  // Sampling pacer and mean value unit.

  // The pacer runs only while an acquisition is under way.
  assign run = state != ST_IDLE && !i_rst_in;

  ssgr_pacer #(
    .FAST_PER(FAST_PER),
    .FAST_SMP(FAST_SMP),
    .SLOW_PER(SLOW_PER),
    .SLOW_SMP(SLOW_SMP)
  ) u_pacer (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_run(run),
    .i_slow(i_cfg.slow),
    .o_take(take),
    .o_sampling(o_sampling)
  );

  // Reset, idle or a closed gate throw away a partial block.
  assign mean_clear = i_rst_in || state == ST_IDLE ||
                      (is_gate && !i_trig);

  ssgr_mean #(
    .DW(WORD_W),
    .LW(MEAN_LW)
  ) u_mean (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_clear(mean_clear),
    .i_add(take && state == ST_ACQ),
    .i_data(i_sample),
    .i_log2(i_cfg.mean_log2),
    .o_done(mean_done),
    .o_mean(mean_val)
  );

  // ============================================================
  // Acquisition sequencer.

  // Mode decode; any hold mode but the two named ones is a gate.
  always_comb begin
    is_normal = i_cfg.hold == HOLD_NORMAL;
    is_shold = i_cfg.hold == HOLD_SAMPLE;
    is_gate = !is_normal && !is_shold;
    trig_rise = i_trig && !trig_q && !i_rst_in;
    gate_open = i_trig && !i_rst_in;
  end

  // Next state and trigger history.
  always_comb begin
    next_trig = trig_q;
    if (!i_rst_in) begin
      next_trig = i_trig;
    end
    next_state = state;
    if (i_rst_in) begin
      next_state = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (is_normal || (is_shold && trig_rise) ||
              (is_gate && gate_open)) begin
            next_state = ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (mean_done) begin
            next_state = ST_WRITE;
          end else if (is_gate && !i_trig) begin
            next_state = ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (is_normal || (is_gate && i_trig)) begin
            next_state = ST_ACQ;
          end else begin
            next_state = ST_IDLE;
          end
        end
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      trig_q <= 1'b0;
    end else begin
      state <= next_state;
      trig_q <= next_trig;
    end
  end

  trig_ignored_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_rst_in |=> trig_q == $past(trig_q))
    else $error("Trigger history moved while reset was high.");

  reset_idles_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_rst_in ##1 i_rst_in |-> state == ST_IDLE && !o_word_new)
    else $error("Acquisition went on under reset input.");

  shold_start_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    state == ST_IDLE && is_shold && !i_rst_in && !i_trig
      |=> state == ST_IDLE)
    else $error("Sampling hold started without a trigger edge.");

  // ============================================================
  // Input word and lamps.

  // Word priority: reset, internal fault, sensor state, then data.
  always_comb begin
    any_fault = i_health.cpu_fault || i_health.cal_fault ||
                i_health.set_fault;
    base = (state == ST_WRITE) ? mean_val : o_word;
    if (i_cfg.compare) begin
      base[BIT_BREAK] = i_health.sensor_break;
      base[BIT_OVER] = i_health.overflow;
    end
    if (i_rst_in) begin
      next_word = W_SENTINEL;
    end else if (i_health.cpu_fault) begin
      next_word = W_CPU_ERR;
    end else if (i_health.cal_fault) begin
      next_word = W_CAL_ERR;
    end else if (i_health.set_fault) begin
      next_word = W_SET_ERR;
    end else if (!i_cfg.compare && i_health.sensor_break) begin
      next_word = W_BREAK;
    end else if (!i_cfg.compare && i_health.overflow) begin
      next_word = W_OVER;
    end else begin
      next_word = base;
    end
    next_new = state == ST_WRITE && !i_rst_in;
    next_err = any_fault;
    next_brk = i_health.sensor_break;
  end

  // Word and lamp registers; the word starts at the sentinel.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_word <= W_SENTINEL;
      o_word_new <= 1'b0;
      o_err_lamp <= 1'b0;
      o_break_lamp <= 1'b0;
    end else begin
      o_word <= next_word;
      o_word_new <= next_new;
      o_err_lamp <= next_err;
      o_break_lamp <= next_brk;
    end
  end

  sentinel_word_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_rst_in |=> o_word == W_SENTINEL)
    else $error("Reset input did not give the sentinel word.");

  cpu_fault_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    !i_rst_in && i_health.cpu_fault
      |=> o_word == W_CPU_ERR && o_err_lamp)
    else $error("Processor fault not reported.");

  break_code_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    !i_rst_in && !any_fault && i_health.sensor_break
      |=> o_break_lamp &&
          ($past(i_cfg.compare) ? o_word[BIT_BREAK] : o_word == W_BREAK))
    else $error("Sensor break not reported.");

  over_code_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    !i_rst_in && !any_fault && !i_health.sensor_break &&
      i_health.overflow
      |=> ($past(i_cfg.compare) ? o_word[BIT_OVER] : o_word == W_OVER))
    else $error("Overflow not reported.");

  write_step_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    mean_done && state == ST_ACQ && !i_rst_in ##1 !i_rst_in
      |=> o_word_new)
    else $error("Finished mean not written as its own step.");

  // ============================================================
  // Command answers.

  // Checks run in order: code, parameter, mode, teach conditions.
  always_comb begin
    op = i_cmd[15:8];
    param = i_cmd[7:0];
    next_resp = o_resp;
    next_resp_valid = i_cmd_valid;
    if (i_cmd_valid) begin
      if (!op_known(op)) begin
        next_resp = R_BAD_CMD;
      end else if (param > PARAM_MAX) begin
        next_resp = R_BAD_PARAM;
      end else if (op_norm_only(op) && !is_normal) begin
        next_resp = R_MODE_ERR;
      end else if (op == OP_TEACH && (i_rst_in ||
                   i_health.sensor_break || i_health.overflow)) begin
        next_resp = R_TEACH_ERR;
      end else begin
        next_resp = i_cmd;
      end
    end
  end

  // Command answer registers.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_resp <= '0;
      o_resp_valid <= 1'b0;
    end else begin
      o_resp <= next_resp;
      o_resp_valid <= next_resp_valid;
    end
  end

  bad_cmd_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_cmd_valid && !op_known(i_cmd[15:8])
      |=> o_resp_valid && o_resp == R_BAD_CMD)
    else $error("Unknown command not answered with E000.");

  bad_param_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_cmd_valid && op_known(i_cmd[15:8]) && i_cmd[7:0] > PARAM_MAX
      |=> o_resp == R_BAD_PARAM)
    else $error("Parameter range error not answered with E001.");

  teach_refused_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_cmd_valid && i_cmd[15:8] == OP_TEACH &&
      i_cmd[7:0] <= PARAM_MAX &&
      (i_rst_in || i_health.sensor_break || i_health.overflow)
      |=> o_resp == R_TEACH_ERR)
    else $error("Teach not refused with E002.");

  mode_refused_a: assert property (
    @(posedge i_mclk) disable iff (i_srst)
    i_cmd_valid && op_norm_only(i_cmd[15:8]) &&
      i_cmd[7:0] <= PARAM_MAX && !is_normal
      |=> o_resp == R_MODE_ERR)
    else $error("Normal-only command not refused with E003.");

endmodule

// ==== dv/ssgr_ctrl_model.sv ====
`timescale 1ns/10ps
// ====================
// Controller model: owns the reset input and the command word.
module ssgr_ctrl_model
  import ssgr_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [WORD_W-1:0] i_word,
  input wire logic i_word_new,
  output logic o_rst_in,
  output logic [WORD_W-1:0] o_cmd,
  output logic o_cmd_valid
);
  // Quiet outputs from time zero.
  initial begin
    o_rst_in = 1'b0;
    o_cmd = 16'h0000;
    o_cmd_valid = 1'b0;
  end
  // Holds reset until the sentinel shows, plus some slack cycles.
  task automatic clear_word(input int extra);
    int n;
    n = 0;
    @(posedge i_mclk);
    #1 o_rst_in = 1'b1;
    @(posedge i_mclk);
    #1;
    while (i_word !== W_SENTINEL && n < 20) begin
      @(posedge i_mclk);
      #1 n++;
    end
    repeat (extra) @(posedge i_mclk);
    @(posedge i_mclk);
    #1 o_rst_in = 1'b0;
  endtask
  // Sets the reset input level.
  task automatic set_rst(input logic v);
    @(posedge i_mclk);
    #1 o_rst_in = v;
  endtask
  // Presents one command and leaves the strobe high; callers may chain them.
  task automatic send(input logic [WORD_W-1:0] c);
    @(posedge i_mclk);
    #1 o_cmd_valid = 1'b1;
    o_cmd = c;
  endtask
  // Drops the command strobe.
  task automatic idle();
    @(posedge i_mclk);
    #1 o_cmd_valid = 1'b0;
  endtask
  // Waits up to lim cycles for the write strobe; ok tells whether it was seen.
  task automatic wait_word(input int lim, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    while (!ok && n < lim) begin
      @(posedge i_mclk);
      #2 ok = (i_word_new === 1'b1);
      n++;
    end
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/10ps
// ====================
// Self-checking bench for the sampling readout block.
module tb
  import ssgr_pkg::*;
;
  localparam int FP = 20;
  localparam int FS = 6;
  localparam int SP = 40;
  localparam int SS = 12;
  logic clk = 1'b0;
  logic srst, trig, rst_in, cv, wnew, elamp, blamp, samp, rv, ok, load;
  logic samp_d, rst_d, pend, chk_w;
  logic [15:0] smp, cmd, word, resp, nv, pexp;
  logic [31:0] lfsr = 32'h831b47e8;
  logic [31:0] v;
  logic [7:0] op_r, pr;
  ssgr_cfg_t cfg;
  ssgr_health_t hl;
  logic [15:0] q[$];
  int n_fail, n_checks, cyc, rise_c, n_rise, n_word, sum, i, r0, w0;
  // ====================
  // Clock, instances and helpers.
  always #50 clk = ~clk;
  ssgr_top #(.FAST_PER(FP), .FAST_SMP(FS), .SLOW_PER(SP), .SLOW_SMP(SS))
    ssgr_top_inst (.i_mclk(clk), .i_srst(srst), .i_trig(trig),
    .i_rst_in(rst_in), .i_cfg(cfg), .i_sample(smp), .i_health(hl),
    .i_cmd_valid(cv), .i_cmd(cmd), .o_word(word), .o_word_new(wnew),
    .o_err_lamp(elamp), .o_break_lamp(blamp), .o_sampling(samp),
    .o_resp(resp), .o_resp_valid(rv));
  ssgr_ctrl_model ssgr_ctrl_model_inst (.i_mclk(clk), .i_word(word),
    .i_word_new(wnew), .o_rst_in(rst_in), .o_cmd(cmd), .o_cmd_valid(cv));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
    return lfsr;
  endfunction
  function automatic logic [15:0] exp_resp(logic [15:0] c, ssgr_hold_t h,
      logic r, ssgr_health_t s);
    logic [7:0] op;
    op = c[15:8];
    if (!(op inside {OP_TEACH, OP_NORM_A, OP_NORM_B, OP_NORM_C}))
      return R_BAD_CMD;
    if (c[7:0] > PARAM_MAX) return R_BAD_PARAM;
    if (op != OP_TEACH && h != HOLD_NORMAL) return R_MODE_ERR;
    if (op == OP_TEACH && (r | s.sensor_break | s.overflow))
      return R_TEACH_ERR;
    return c;
  endfunction
  function automatic logic [15:0] fexp(ssgr_health_t s);
    if (s.cpu_fault) return W_CPU_ERR;
    if (s.cal_fault) return W_CAL_ERR;
    if (s.set_fault) return W_SET_ERR;
    if (s.sensor_break) return W_BREAK;
    return W_OVER;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cycle count with a ceiling against hangs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // Loads a fresh sample value just after the edge following a window start.
  always @(posedge clk) if (load) begin
    #1 smp = nv;
    load = 1'b0;
  end
  // ====================
  // Reference model: windows, means, sentinel and command answers.
  always @(negedge clk) begin
    if (samp && !samp_d) begin
      n_rise++;
      if (chk_w && q.size() > 0) chk(16'(cyc - rise_c), 16'(cfg.slow ? SP : FP));
      rise_c = cyc;
      nv = 16'(rnd()) & 16'h0fff;
      q.push_back(nv);
      load = 1'b1;
    end
    if (!samp && samp_d && chk_w && !rst_in) chk(16'(cyc - rise_c), 16'(cfg.slow ? SS : FS));
    if (wnew) begin
      n_word++;
      sum = 0;
      foreach (q[k]) sum += q[k];
      if (chk_w) begin
        chk(16'(q.size()), 16'(1 << cfg.mean_log2));
        chk(word, 16'(sum >> cfg.mean_log2));
      end
      q.delete();
    end
    if (rst_in) q.delete();
    if (rst_in && rst_d) chk(word, W_SENTINEL);
    if (pend || rv) begin
      chk({15'h0, rv}, {15'h0, pend});
      if (pend) chk(resp, pexp);
    end
    pend = cv;
    pexp = exp_resp(cmd, cfg.hold, rst_in, hl);
    samp_d = samp;
    rst_d = rst_in;
  end
  // ====================
  // Main sequence.
  initial begin
    {srst, trig, load, samp_d, rst_d, pend, chk_w} = 7'b1000000;
    cfg = '0;
    hl = '0;
    smp = 16'h0000;
    nv = 16'h0000;
    step(6);
    srst = 1'b0;
    @(negedge clk) chk(word, W_SENTINEL);
    // Free-running blocks over both speeds and several mean counts.
    for (i = 0; i < 4; i++) begin
      chk_w = 1'b0;
      cfg.slow = i[1];
      cfg.mean_log2 = 2'(3 * i);
      ssgr_ctrl_model_inst.clear_word(i);
      chk_w = 1'b1;
      repeat (2) begin
        ssgr_ctrl_model_inst.wait_word(2000, ok);
        chk({15'h0, ok}, 16'h1);
      end
    end
    // Commands back to back, boundaries first, then random ones.
    chk_w = 1'b0;
    ssgr_ctrl_model_inst.send(16'hc163);
    ssgr_ctrl_model_inst.send(16'hc164);
    ssgr_ctrl_model_inst.send(16'h1234);
    ssgr_ctrl_model_inst.set_rst(1'b1);
    for (i = 0; i < 40; i++) begin
      v = rnd();
      if (i == 20) ssgr_ctrl_model_inst.set_rst(1'b0);
      cfg = ssgr_cfg_t'(v[13:8]);
      trig = v[14];
      hl = ssgr_health_t'(v[20:16]);
      op_r = v[3] ? OP_NORM_C : (v[2] ? OP_NORM_B : OP_NORM_A);
      if (v[5]) op_r = 8'h07;
      if (v[4]) op_r = OP_TEACH;
      pr = v[6] ? v[31:24] : 8'(v[30:24] % 100);
      ssgr_ctrl_model_inst.send({op_r, pr});
    end
    ssgr_ctrl_model_inst.idle();
    // Fault codes and lamps, one fault at a time, then all together.
    cfg = '0;
    trig = 1'b0;
    for (i = 0; i < 6; i++) begin
      hl = (i < 5) ? ssgr_health_t'(5'h10 >> i) : ssgr_health_t'(5'h1f);
      step(3);
      chk(word, fexp(hl));
      chk({14'h0, elamp, blamp}, {14'h0, |hl[4:2], hl.sensor_break});
    end
    hl = ssgr_health_t'(5'h03);
    cfg.compare = 1'b1;
    step(3);
    chk({14'h0, word[15:14]}, 16'h3);
    hl = '0;
    cfg = '0;
    // A second synchronous reset in mid-run brings back the start state.
    srst = 1'b1;
    step(2);
    chk(word, W_SENTINEL);
    chk({12'h0, elamp, blamp, wnew, rv}, 16'h0);
    srst = 1'b0;
    // Sampling hold: nothing without a trigger, one block per edge.
    cfg.hold = HOLD_SAMPLE;
    ssgr_ctrl_model_inst.clear_word(0);
    chk_w = 1'b1;
    r0 = n_rise;
    step(3 * FP);
    chk(16'(n_rise - r0), 16'h0);
    ssgr_ctrl_model_inst.set_rst(1'b1);
    step(1);
    trig = 1'b1;
    step(2);
    trig = 1'b0;
    ssgr_ctrl_model_inst.set_rst(1'b0);
    step(2 * FP);
    chk(16'(n_rise - r0), 16'h0);
    w0 = n_word;
    trig = 1'b1;
    step(2);
    trig = 1'b0;
    ssgr_ctrl_model_inst.wait_word(2 * FP, ok);
    chk({15'h0, ok}, 16'h1);
    step(3 * FP);
    chk(16'(n_word - w0), 16'h1);
    // Gate mode: early close, close under reset, then a full block.
    cfg.hold = HOLD_GATE;
    cfg.mean_log2 = 2'd2;
    ssgr_ctrl_model_inst.clear_word(0);
    w0 = n_word;
    trig = 1'b1;
    step(2 * FP + FS);
    chk_w = 1'b0;
    trig = 1'b0;
    step(20);
    q.delete();
    chk(16'(n_word - w0), 16'h0);
    trig = 1'b1;
    step(FP + 2);
    ssgr_ctrl_model_inst.set_rst(1'b1);
    step(2);
    trig = 1'b0;
    ssgr_ctrl_model_inst.set_rst(1'b0);
    step(2 * FP);
    chk(word, W_SENTINEL);
    chk(16'(n_word - w0), 16'h0);
    ssgr_ctrl_model_inst.set_rst(1'b1);
    r0 = n_rise;
    repeat (3) begin
      step(2);
      trig = ~trig;
    end
    chk(16'(n_rise - r0), 16'h0);
    trig = 1'b1;
    ssgr_ctrl_model_inst.set_rst(1'b0);
    chk_w = 1'b1;
    ssgr_ctrl_model_inst.wait_word(5 * FP + 20, ok);
    chk({15'h0, ok}, 16'h1);
    chk_w = 1'b0;
    trig = 1'b0;
    step(4);
    report_and_stop();
  end
endmodule
